// file: rtl/usbdcs_pkg.sv
// constants, field layouts and state types of the usb device control/auto-dma/suspend block
package usbdcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_EP_CR  = 8'h00;
  localparam logic [7:0] OFS_CTRL_EP_CNT = 8'h04;
  localparam logic [7:0] OFS_DATA_LO     = 8'h08;
  localparam logic [7:0] OFS_DATA_HI     = 8'h0C;
  localparam logic [7:0] OFS_INTR_STAT   = 8'h10;
  localparam logic [7:0] OFS_INTR_CLR    = 8'h14;
  localparam logic [7:0] OFS_INTR_EN     = 8'h18;
  localparam logic [7:0] OFS_PWR         = 8'h1C;
  localparam logic [7:0] OFS_EP1_CFG     = 8'h20;
  localparam logic [7:0] OFS_EP1_STAT    = 8'h24;

  // field positions
  localparam int CR_IN_ACKED_BIT = 6;
  localparam int CR_SETUP_BIT    = 7;
  localparam int CNT_DV_BIT      = 7;
  localparam int PWR_LP_BIT      = 0;
  localparam int PWR_SUSP_BIT    = 1;
  localparam int CFG_AUTO_BIT    = 0;
  localparam int CFG_DIR_BIT     = 1;
  localparam int CFG_CNT_LSB     = 8;
  localparam int CFG_THR_LSB     = 16;

  // interrupt status bits
  localparam int IRQ_SETUP  = 0;
  localparam int IRQ_IN_ACK = 1;
  localparam int IRQ_OUT    = 2;
  localparam int IRQ_SOF    = 3;
  localparam int IRQ_SUSP   = 4;
  localparam int IRQ_WAKE   = 5;
  localparam int IRQ_EP1    = 6;
  localparam int IRQ_W      = 7;

  // reset values
  localparam logic [31:0] EP1_CFG_RST  = 32'h0008_0800;
  localparam logic [2:0]  CNT_RST      = 3'h0;

  // buffers
  localparam int CTRL_BUF_BYTES   = 8;
  localparam int SHARED_MEM_BYTES = 512;
  localparam int EP1_BUF_DEPTH    = 32;
  localparam int EP1_AW           = 5;
  localparam logic [3:0] EP_AUTO  = 4'h1;

  // suspend timing
  localparam int CLK_MHZ      = 125;
  localparam int SUSP_TIME_US = 3000;
  localparam int SUSP_CYCLES  = SUSP_TIME_US * CLK_MHZ;
  localparam int SOF_CNT_W    = 20;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    PID_OUT   = 2'b00,
    PID_IN    = 2'b01,
    PID_SETUP = 2'b10,
    PID_SOF   = 2'b11
  } usbdcs_pid_type;

  typedef enum logic [1:0] {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10
  } usbdcs_hs_type;

  typedef enum logic [2:0] {
    MODE_DISABLED = 3'b000,
    MODE_NAK_ALL  = 3'b001,
    MODE_ACK_OUT  = 3'b010,
    MODE_ACK_IN   = 3'b011,
    MODE_STALL    = 3'b100,
    MODE_NAK_IN   = 3'b101,
    MODE_NAK_OUT  = 3'b110
  } usbdcs_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_TX0  = 3'b010,
    ST_ACK0 = 3'b011,
    ST_TX1  = 3'b100,
    ST_ACK1 = 3'b101
  } usbdcs_state_type;

  typedef enum logic [1:0] {
    RX_SETUP = 2'b00,
    RX_EP0   = 2'b01,
    RX_EP1   = 2'b10,
    RX_DROP  = 2'b11
  } usbdcs_rx_type;

endpackage

// file: rtl/usbdcs_mem_if.sv
// carrier between the control logic and the auto-dma endpoint buffer
`timescale 1ns/10ps
`default_nettype none
interface usbdcs_mem_if;
  import usbdcs_pkg::*;
  logic              wr_en;
  logic [EP1_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              rd_en;
  logic [EP1_AW-1:0] rd_addr;
  logic [7:0]        rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: rtl/usbdcs_ep_buf.sv
// dedicated auto-dma endpoint buffer, registered read
`timescale 1ns/10ps
`default_nettype none
module usbdcs_ep_buf
  import usbdcs_pkg::*;
(
  input wire logic   pclk,
  usbdcs_mem_if.mem  mif
);
  logic [7:0] mem_ff [EP1_BUF_DEPTH];
  logic [7:0] rd_ff;

  always_ff @(posedge pclk)
  begin
    if (mif.wr_en)
      mem_ff[mif.wr_addr] <= mif.wr_data;
  end

  // read data holds until the next read, the fetch stage relies on it
  always_ff @(posedge pclk)
  begin
    if (mif.rd_en)
      rd_ff <= mem_ff[mif.rd_addr];
  end

  assign mif.rd_data = rd_ff;
endmodule // usbdcs_ep_buf
`default_nettype wire

// file: rtl/usbdcs_top.sv
// usb device control endpoint, auto-dma endpoint and suspend/low-power logic with apb registers
`timescale 1ns/10ps
`default_nettype none
module usbdcs_top
  import usbdcs_pkg::*;
#(
  parameter int SUSP_CYCLES_P = SUSP_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_pid,
  input  wire logic [3:0]  tok_ep,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             tx_zlp,
  input  wire logic        tx_ready,
  output logic             hs_valid,
  output logic [1:0]       hs_code,
  input  wire logic        host_ack,
  output logic             dma_req,
  input  wire logic        dma_wr_valid,
  input  wire logic [7:0]  dma_wr_data,
  output logic             dma_wr_ready,
  output logic             dma_rd_valid,
  output logic [7:0]       dma_rd_data,
  input  wire logic        dma_rd_ready,
  input  wire logic        dplus,
  output logic             usb_clk_en,
  output logic             lf_clk_en,
  output logic             irq,
  output logic             wake_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and wires
  usbdcs_state_type  state_ff, nxt_state;
  usbdcs_rx_type     rx_kind_ff;
  usbdcs_mode_type   mode_ff;
  logic [1:0]        hs_pend_ff;
  logic [7:0]        idx_ff;
  logic [7:0]        data_ff [CTRL_BUF_BYTES];
  logic [3:0]        cnt_ff;
  logic              dv_ff, setup_ff, inack_ff;
  logic [IRQ_W-1:0]  stat_ff, en_ff, ev;
  logic              lp_ff, susp_ff, dp_q_ff;
  logic [SOF_CNT_W-1:0] sof_cnt_ff;
  logic [31:0]       cfg_ff, prdata_ff;
  logic              hs_valid_ff;
  logic [1:0]        hs_code_ff;
  logic [EP1_AW:0]   wp_ff, rp_ff, level;
  logic              rd_pend_ff, out_vld_ff;
  logic              wr_acc, rd_setup, unmapped, idle_tok, rx_end, ep_in, buf_full;
  logic              consume, issue, tx0_done, tx1_done;
  logic [7:0]        ep1_cnt;
  logic [EP1_AW:0]   thr;
  usbdcs_mem_if      mif ();

  usbdcs_ep_buf u_buf (
    .pclk (pclk),
    .mif  (mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read data captured in setup phase
  assign pready   = 1'b1;
  assign unmapped = (paddr[1:0] != 2'b00) || (paddr > OFS_EP1_STAT);
  assign pslverr  = psel && penable && unmapped;
  assign wr_acc   = psel && penable && pwrite && !unmapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata   = prdata_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (rd_setup)
    begin
      case (paddr)
        OFS_CTRL_EP_CR:  prdata_ff <= {24'h0, setup_ff, inack_ff, 3'h0, mode_ff};
        OFS_CTRL_EP_CNT: prdata_ff <= {24'h0, dv_ff, 3'h0, cnt_ff};
        OFS_DATA_LO:     prdata_ff <= {data_ff[3], data_ff[2], data_ff[1], data_ff[0]};
        OFS_DATA_HI:     prdata_ff <= {data_ff[7], data_ff[6], data_ff[5], data_ff[4]};
        OFS_INTR_STAT:   prdata_ff <= {25'h0, stat_ff};
        OFS_INTR_EN:     prdata_ff <= {25'h0, en_ff};
        OFS_PWR:         prdata_ff <= {30'h0, susp_ff, lp_ff};
        OFS_EP1_CFG:     prdata_ff <= cfg_ff;
        OFS_EP1_STAT:    prdata_ff <= {26'h0, level};
        default:         prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token / transaction sequencing
  assign idle_tok = (state_ff == ST_IDLE) && tok_valid;
  assign rx_end   = (state_ff == ST_RX) && rx_valid && rx_last;
  assign ep_in    = !cfg_ff[CFG_DIR_BIT];
  assign ep1_cnt  = cfg_ff[CFG_CNT_LSB +: 8];
  assign tx0_done = (state_ff == ST_TX0) && tx_ready && tx_last;
  assign tx1_done = (state_ff == ST_TX1) && tx_valid && tx_ready && tx_last;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (tok_valid && tok_ep == 4'h0 && tok_pid == PID_IN && mode_ff == MODE_ACK_IN)
          nxt_state = ST_TX0;
        else if (tok_valid && tok_ep == EP_AUTO && tok_pid == PID_IN && cfg_ff[CFG_AUTO_BIT] && ep_in
                 && ep1_cnt != 8'h00)
          nxt_state = ST_TX1;
        else if (tok_valid && (tok_pid == PID_SETUP || tok_pid == PID_OUT))
          nxt_state = ST_RX;
      ST_RX:   if (rx_valid && rx_last) nxt_state = ST_IDLE;
      ST_TX0:  if (tx0_done) nxt_state = ST_ACK0;
      ST_TX1:  if (tx1_done) nxt_state = ST_ACK1;
      ST_ACK0: if (host_ack || tok_valid) nxt_state = ST_IDLE;
      ST_ACK1: if (host_ack || tok_valid) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // data-stage kind and handshake chosen when the token is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_kind_ff <= RX_DROP;
      hs_pend_ff <= HS_NAK;
    end
    else if (idle_tok && tok_ep == 4'h0 && tok_pid == PID_SETUP)
    begin
      rx_kind_ff <= RX_SETUP;
      hs_pend_ff <= HS_ACK;
    end
    else if (idle_tok && tok_ep == 4'h0 && tok_pid == PID_OUT)
    begin
      rx_kind_ff <= (mode_ff == MODE_ACK_OUT) ? RX_EP0 : RX_DROP;
      hs_pend_ff <= (mode_ff == MODE_ACK_OUT) ? HS_ACK : (mode_ff == MODE_STALL) ? HS_STALL : HS_NAK;
    end
    else if (idle_tok && tok_ep == EP_AUTO && tok_pid == PID_OUT)
    begin
      rx_kind_ff <= (cfg_ff[CFG_AUTO_BIT] && !ep_in) ? RX_EP1 : RX_DROP;
      hs_pend_ff <= (cfg_ff[CFG_AUTO_BIT] && !ep_in) ? HS_ACK : HS_NAK;
    end
    else if (idle_tok && tok_pid == PID_SETUP)
    begin
      rx_kind_ff <= RX_DROP;
      hs_pend_ff <= HS_STALL;
    end
    else if ((state_ff == ST_RX) && rx_valid && rx_kind_ff == RX_EP1 && buf_full)
      hs_pend_ff <= HS_NAK; // overrun, host must retry
  end

  // byte index in data stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_ff <= 8'h00;
    else if (state_ff == ST_IDLE)
      idx_ff <= 8'h00;
    else if ((state_ff == ST_RX && rx_valid) || (state_ff == ST_TX0 && tx_ready)
             || (state_ff == ST_TX1 && consume))
      idx_ff <= idx_ff + 8'h01;
  end

  // handshake: NAK/STALL for refused IN, pending code at end of data stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_valid_ff <= 1'b0;
      hs_code_ff  <= HS_NAK;
    end
    else if (rx_end)
    begin
      hs_valid_ff <= 1'b1;
      hs_code_ff  <= hs_pend_ff;
    end
    else if (idle_tok && tok_pid == PID_IN && nxt_state == ST_IDLE)
    begin
      hs_valid_ff <= 1'b1;
      hs_code_ff  <= (tok_ep == 4'h0 && mode_ff == MODE_STALL) ? HS_STALL : HS_NAK;
    end
    else
      hs_valid_ff <= 1'b0;
  end
  assign hs_valid = hs_valid_ff;
  assign hs_code  = hs_code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // control endpoint: dedicated 8-byte register buffer
  for (genvar g = 0; g < CTRL_BUF_BYTES; g++)
  begin : g_ctrl_byte
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        data_ff[g] <= 8'h00;
      else if (state_ff == ST_RX && rx_valid && idx_ff == 8'(g)
               && (rx_kind_ff == RX_SETUP || rx_kind_ff == RX_EP0))
        data_ff[g] <= rx_data;
      else if (wr_acc && paddr == ((g < 4) ? OFS_DATA_LO : OFS_DATA_HI))
        data_ff[g] <= pwdata[8*(g%4) +: 8];
    end
  end

  assign tx_valid = (state_ff == ST_TX0) || ((state_ff == ST_TX1) && out_vld_ff);
  assign tx_zlp   = (state_ff == ST_TX0) && (cnt_ff == 4'h0);
  assign tx_data  = (state_ff == ST_TX0) ? data_ff[idx_ff[2:0]] : mif.rd_data;
  assign tx_last  = (state_ff == ST_TX0) ? (cnt_ff == 4'h0 || idx_ff[3:0] == cnt_ff - 4'h1)
                                         : (idx_ff == ep1_cnt - 8'h01);

  // mode: software sets, hardware drops to NAK-IN after IN data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ff <= MODE_DISABLED;
    else if (tx0_done)
      mode_ff <= MODE_NAK_IN;
    else if (wr_acc && paddr == OFS_CTRL_EP_CR)
      mode_ff <= usbdcs_mode_type'(pwdata[2:0]);
  end

  // sticky flags in control register, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setup_ff <= 1'b0;
      inack_ff <= 1'b0;
    end
    else
    begin
      setup_ff <= ev[IRQ_SETUP] ||
                  (setup_ff && !(wr_acc && paddr == OFS_CTRL_EP_CR && pwdata[CR_SETUP_BIT]));
      inack_ff <= ev[IRQ_IN_ACK] ||
                  (inack_ff && !(wr_acc && paddr == OFS_CTRL_EP_CR && pwdata[CR_IN_ACKED_BIT]));
    end
  end

  // byte count and data valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= {1'b0, CNT_RST};
      dv_ff  <= 1'b0;
    end
    else if (rx_end && (rx_kind_ff == RX_SETUP || rx_kind_ff == RX_EP0))
    begin
      cnt_ff <= (idx_ff >= 8'h07) ? 4'h8 : idx_ff[3:0] + 4'h1;
      dv_ff  <= 1'b1;
    end
    else if (wr_acc && paddr == OFS_CTRL_EP_CNT)
    begin
      cnt_ff <= (pwdata[3:0] > 4'h8) ? 4'h8 : pwdata[3:0];
      dv_ff  <= pwdata[CNT_DV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-dma endpoint: dedicated buffer, dma refill/drain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_ff <= EP1_CFG_RST;
    else if (wr_acc && paddr == OFS_EP1_CFG)
      cfg_ff <= pwdata;
  end

  assign level    = wp_ff - rp_ff;
  assign buf_full = (level == 6'(EP1_BUF_DEPTH));
  assign thr      = cfg_ff[CFG_THR_LSB +: 6];
  assign dma_wr_ready = cfg_ff[CFG_AUTO_BIT] && ep_in && !buf_full;
  assign mif.wr_en   = ep_in ? (dma_wr_valid && dma_wr_ready)
                             : (state_ff == ST_RX && rx_valid && rx_kind_ff == RX_EP1 && !buf_full);
  assign mif.wr_addr = wp_ff[EP1_AW-1:0];
  assign mif.wr_data = ep_in ? dma_wr_data : rx_data;
  // one-deep fetch stage; a byte costs three cycles, ample for full speed
  assign issue       = !rd_pend_ff && !out_vld_ff && level != 6'h00;
  assign mif.rd_en   = issue;
  assign mif.rd_addr = rp_ff[EP1_AW-1:0];
  assign consume     = out_vld_ff && (ep_in ? (state_ff == ST_TX1 && tx_ready) : dma_rd_ready);
  assign dma_rd_valid = !ep_in && out_vld_ff;
  assign dma_rd_data  = mif.rd_data;
  // in: ask for refill while at least thr bytes are free; out: drain at threshold or once the packet ended
  assign dma_req = cfg_ff[CFG_AUTO_BIT] &&
                   (ep_in ? (level <= 6'(EP1_BUF_DEPTH) - thr)
                          : (level >= thr || (level != 6'h00 && state_ff != ST_RX) || out_vld_ff));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_ff      <= '0;
      rp_ff      <= '0;
      rd_pend_ff <= 1'b0;
      out_vld_ff <= 1'b0;
    end
    else if (!cfg_ff[CFG_AUTO_BIT])
    begin
      wp_ff      <= '0;
      rp_ff      <= '0;
      rd_pend_ff <= 1'b0;
      out_vld_ff <= 1'b0;
    end
    else
    begin
      if (mif.wr_en)
        wp_ff <= wp_ff + 6'h01;
      if (issue)
        rp_ff <= rp_ff + 6'h01;
      rd_pend_ff <= issue;
      out_vld_ff <= rd_pend_ff || (out_vld_ff && !consume);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // suspend detection and low power
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sof_cnt_ff <= '0;
    else if (tok_valid && tok_pid == PID_SOF)
      sof_cnt_ff <= '0;
    else if (sof_cnt_ff <= SOF_CNT_W'(SUSP_CYCLES_P))
      sof_cnt_ff <= sof_cnt_ff + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      susp_ff <= 1'b0;
      lp_ff   <= 1'b0;
      dp_q_ff <= 1'b1;
    end
    else
    begin
      susp_ff <= (sof_cnt_ff > SOF_CNT_W'(SUSP_CYCLES_P));
      if (wr_acc && paddr == OFS_PWR)
        lp_ff <= pwdata[PWR_LP_BIT];
      dp_q_ff <= dplus;
    end
  end

  // only the low-frequency clock survives low power
  assign usb_clk_en = !lp_ff;
  assign lf_clk_en  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one clear, enable mask on irq only, wake_irq unmasked
  always_comb
  begin
    ev             = '0;
    ev[IRQ_SETUP]  = rx_end && rx_kind_ff == RX_SETUP;
    ev[IRQ_IN_ACK] = (state_ff == ST_ACK0) && host_ack;
    ev[IRQ_OUT]    = rx_end && rx_kind_ff == RX_EP0;
    ev[IRQ_SOF]    = tok_valid && tok_pid == PID_SOF;
    ev[IRQ_SUSP]   = !susp_ff && (sof_cnt_ff > SOF_CNT_W'(SUSP_CYCLES_P));
    ev[IRQ_WAKE]   = lp_ff && dp_q_ff && !dplus;
    ev[IRQ_EP1]    = (state_ff == ST_ACK1) && host_ack;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_ff <= '0;
      en_ff   <= '0;
    end
    else
    begin
      stat_ff <= ev | (stat_ff & ~((wr_acc && paddr == OFS_INTR_CLR) ? pwdata[IRQ_W-1:0] : '0));
      if (wr_acc && paddr == OFS_INTR_EN)
        en_ff <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq      = |(stat_ff & en_ff);
  assign wake_irq = stat_ff[IRQ_WAKE];

endmodule // usbdcs_top
`default_nettype wire

// file: verif/usbdcs_checker.sv
// port-level assertions for the usb device control block
`timescale 1ns/10ps
`default_nettype none
module usbdcs_checker
  import usbdcs_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [3:0] tok_ep,
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       hs_valid,
  input wire logic [1:0] hs_code,
  input wire logic       dplus,
  input wire logic       usb_clk_en,
  input wire logic       lf_clk_en,
  input wire logic       wake_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup_pend_ff;
  // open from a setup token on endpoint 0 until its handshake
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) setup_pend_ff <= 1'b0;
    else if (tok_valid) setup_pend_ff <= (tok_pid == PID_SETUP) && (tok_ep == 4'h0);
    else if (hs_valid) setup_pend_ff <= 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  chk_setup_ack: assert property (setup_pend_ff && rx_valid && rx_last |=> hs_valid && hs_code == HS_ACK)
    else $error("setup not acknowledged");
  chk_in_answer: assert property (tok_valid && tok_pid == PID_IN && tok_ep == 4'h0 |=> tx_valid || hs_valid)
    else $error("in token left unanswered");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped before taken");
  chk_in_end: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("tx kept going after last byte");
  chk_hs_pulse: assert property (hs_valid |=> !hs_valid)
    else $error("handshake longer than one cycle");
  chk_out_no_tx: assert property (rx_valid |-> !tx_valid)
    else $error("transmit during received data");
  chk_wake_cause: assert property ($rose(wake_irq) |-> !$past(dplus))
    else $error("wake without dplus low");
  chk_lf_clk: assert property (!usb_clk_en |-> lf_clk_en)
    else $error("low frequency clock stopped");
endmodule // usbdcs_checker
`default_nettype wire

// file: verif/usbdcs_host_model.sv
// behavioural usb host on the token, data and handshake lines
`timescale 1ns/10ps
`default_nettype none
module usbdcs_host_model
  import usbdcs_pkg::*;
(
  input  wire logic       pclk,
  output logic            tok_valid,
  output logic [1:0]      tok_pid,
  output logic [3:0]      tok_ep,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       hs_valid,
  input  wire logic [1:0] hs_code,
  output logic            host_ack,
  output logic            dplus
);
  logic [7:0] got [8];
  int         n_got;
  initial
  begin
    {tok_valid, rx_valid, rx_last, host_ack, tx_ready, tok_pid, tok_ep, rx_data} = '0;
    dplus = 1'b1;
  end
  // sof restarts the device's suspend count
  task automatic tok(input usbdcs_pid_type p, input logic [3:0] e);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_ep <= e;
    @(posedge pclk);
    tok_valid <= 1'b0;
  endtask
  task automatic data(input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= d[8*i +: 8];
      rx_last <= (i == n - 1);
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // idle data bus shows garbage, not the last byte
    rx_data <= ~rx_data;
  endtask
  task automatic hs(output logic [1:0] c);
    c = 2'h3;
    for (int i = 0; i < 20 && c === 2'h3; i++)
    begin
      @(posedge pclk);
      if (hs_valid) c = hs_code;
    end
  endtask
  // slow host: takes a byte only every other cycle
  task automatic take(input int max);
    n_got = 0;
    for (int i = 0; i < 60 && n_got < max; i++)
    begin
      @(posedge pclk);
      if (tx_valid && tx_ready) got[n_got] = tx_data;
      if (tx_valid && tx_ready) n_got++;
      tx_ready <= !tx_ready && n_got < max;
    end
  endtask
  task automatic ack();
    host_ack <= 1'b1;
    @(posedge pclk);
    host_ack <= 1'b0;
  endtask
  task automatic wake();
    dplus <= 1'b0;
    repeat (3) @(posedge pclk);
    dplus <= 1'b1;
  endtask
endmodule // usbdcs_host_model
`default_nettype wire

// file: verif/tb_usb_device_ctrl_endpoint_suspend.sv
// self-checking bench for the usb device control block
`timescale 1ns/10ps
`default_nettype none
module tb_usb_device_ctrl_endpoint_suspend;
  import usbdcs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, rx_data, tx_data, dma_wr_data, dma_rd_data;
  logic [31:0] pwdata, prdata, rd;
  logic        tok_valid, rx_valid, rx_last, tx_valid, tx_last, tx_zlp, tx_ready, hs_valid, host_ack;
  logic [1:0]  tok_pid, hs_code, hc;
  logic [3:0]  tok_ep;
  logic        dma_req, dma_wr_valid, dma_wr_ready, dma_rd_valid, dma_rd_ready;
  logic        dplus, usb_clk_en, lf_clk_en, irq, wake_irq;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  usbdcs_top #(.SUSP_CYCLES_P(50)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data,
    .tx_last, .tx_zlp, .tx_ready, .hs_valid, .hs_code, .host_ack, .dma_req, .dma_wr_valid, .dma_wr_data,
    .dma_wr_ready, .dma_rd_valid, .dma_rd_data, .dma_rd_ready, .dplus, .usb_clk_en, .lf_clk_en, .irq, .wake_irq);
  usbdcs_host_model host (.pclk, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_data, .rx_last, .tx_valid,
    .tx_data, .tx_ready, .hs_valid, .hs_code, .host_ack, .dplus);
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // run needs under a thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000) fail_count++;
    if (cyc == 4000) give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rd & m, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, dma_wr_valid, dma_wr_data} = '0;
    dma_rd_ready = 1'b1;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rm(OFS_EP1_CFG, 32'hFFFF_FFFF, EP1_CFG_RST, "ep1 cfg reset");
    rm(8'h28, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    chk("unmapped error", 32'(err), 32'h1);
    apb(1'b1, OFS_INTR_EN, 32'h07);
    $display("test reset done");
    host.tok(PID_SETUP, 4'h0);
    host.data(64'h1817161514131211, 8);
    host.hs(hc);
    chk("setup hs", 32'(hc), 32'(HS_ACK));
    rm(OFS_CTRL_EP_CNT, 32'h8F, 32'h88, "setup count");
    rm(OFS_CTRL_EP_CR, 32'h80, 32'h80, "setup flag");
    rm(OFS_DATA_HI, 32'hFFFF_FFFF, 32'h1817_1615, "setup data");
    rm(OFS_INTR_STAT, 32'h07, 32'h01, "setup status");
    chk("setup irq", 32'(irq), 32'h1);
    apb(1'b1, OFS_INTR_CLR, 32'h7F);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test setup done");
    apb(1'b1, OFS_DATA_LO, 32'hA4A3_A2A1);
    apb(1'b1, OFS_CTRL_EP_CNT, 32'h83);
    apb(1'b1, OFS_CTRL_EP_CR, 32'hC3);
    host.tok(PID_IN, 4'h0);
    host.take(3);
    chk("in bytes", {8'h0, host.got[2], host.got[1], host.got[0]}, 32'hA3A2A1);
    host.ack();
    rm(OFS_CTRL_EP_CR, 32'hC7, 32'h45, "mode after in");
    host.tok(PID_IN, 4'h0);
    host.hs(hc);
    chk("in nak", 32'(hc), 32'(HS_NAK));
    $display("test control in done");
    apb(1'b1, OFS_CTRL_EP_CR, 32'h02);
    host.tok(PID_OUT, 4'h0);
    host.data(64'hB2B1, 2);
    host.hs(hc);
    chk("out hs", 32'(hc), 32'(HS_ACK));
    rm(OFS_DATA_LO, 32'hFFFF, 32'hB2B1, "out data");
    rm(OFS_INTR_STAT, 32'h07, 32'h06, "out status");
    apb(1'b1, OFS_CTRL_EP_CR, 32'h06);
    host.tok(PID_OUT, 4'h0);
    host.data(64'hC2C1, 2);
    host.hs(hc);
    chk("out nak", 32'(hc), 32'(HS_NAK));
    rm(OFS_DATA_LO, 32'hFFFF, 32'hB2B1, "data kept");
    apb(1'b1, OFS_CTRL_EP_CR, 32'h04);
    host.tok(PID_IN, 4'h0);
    host.hs(hc);
    chk("in stall", 32'(hc), 32'(HS_STALL));
    $display("test control out done");
    apb(1'b1, OFS_INTR_EN, 32'h10);
    host.tok(PID_SOF, 4'h0);
    apb(1'b1, OFS_INTR_CLR, 32'h10);
    repeat (40) @(posedge pclk);
    rm(OFS_PWR, 32'h2, 32'h0, "not yet suspended");
    repeat (20) @(posedge pclk);
    rm(OFS_PWR, 32'h2, 32'h2, "suspended");
    chk("suspend irq", 32'(irq), 32'h1);
    apb(1'b1, OFS_PWR, 32'h1);
    chk("usb clock off", 32'(usb_clk_en), 32'h0);
    chk("lf clock on", 32'(lf_clk_en), 32'h1);
    host.wake();
    chk("wake irq", 32'(wake_irq), 32'h1);
    host.tok(PID_SOF, 4'h0);
    apb(1'b1, OFS_PWR, 32'h0);
    rm(OFS_PWR, 32'h3, 32'h0, "resumed");
    chk("usb clock on", 32'(usb_clk_en), 32'h1);
    $display("test suspend done");
    apb(1'b1, OFS_EP1_CFG, 32'h0008_0201);
    chk("dma request", 32'(dma_req), 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      dma_wr_valid <= 1'b1;
      dma_wr_data <= 8'h51 + 8'(i);
      do @(posedge pclk); while (dma_wr_ready !== 1'b1);
    end
    dma_wr_valid <= 1'b0;
    host.tok(PID_IN, 4'h1);
    host.take(2);
    chk("ep1 bytes", {16'h0, host.got[1], host.got[0]}, 32'h5251);
    host.ack();
    apb(1'b1, OFS_EP1_CFG, 32'h3);
    host.tok(PID_OUT, 4'h1);
    host.data(64'h6261, 2);
    repeat (6) @(posedge pclk);
    chk("ep1 out", 32'(dma_rd_data), 32'h62);
    $display("test auto dma done");
    give_verdict();
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
endmodule // tb_usb_device_ctrl_endpoint_suspend
bind usbdcs_top usbdcs_checker chk_i (.pclk, .presetn, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_last,
  .tx_valid, .tx_data, .tx_last, .tx_ready, .hs_valid, .hs_code, .dplus, .usb_clk_en, .lf_clk_en, .wake_irq);
`default_nettype wire
